/* cpm_regs.svh */
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH

// register byte offsets on the control bus
`define CPM_OFS_STATUS      32'h0000_0000
`define CPM_OFS_CONTROL     32'h0000_0004
`define CPM_OFS_DECODE      32'h0000_0008

// control register field positions
`define CPM_CTL_SOFT_RESET  0
`define CPM_CTL_SDR_CLOCK   1

// control register reset value
`define CPM_CTL_RESET_VAL   2'h0

// static parallel codes carried on clock and data pins, {clock,data}
`define CPM_PAR_NORMAL      2'h0
`define CPM_PAR_ALIGN       2'h1
`define CPM_PAR_SYNC        2'h2
`define CPM_PAR_POWERDOWN   2'h3

// axi response codes
`define CPM_RESP_OKAY       2'h0
`define CPM_RESP_SLVERR     2'h2

`endif

/* cpm_pkg.sv */
`include "cpm_regs.svh"

package cpm_pkg;

	// pin levels as sampled on the converter clock
	typedef struct packed {
		logic serial_reset;
		logic clock;
		logic data;
		logic enable;
		logic powerdown;
		logic wire_rate;
		logic factor;
		logic format_order;
	} cpm_pins_t;

	// decoded static operating modes
	typedef struct packed {
		logic alignment_pattern_mode;
		logic sync_mode;
		logic powerdown;
		logic coarse_gain;
		logic external_reference;
		logic two_wire;
		logic sdr_clock;
		logic factor_16x;
		logic capture_falling;
		logic offset_binary;
		logic lsb_first;
	} cpm_mode_t;

	// serial programming port as passed to the register file
	typedef struct packed {
		logic clock;
		logic data;
		logic enable;
	} cpm_prog_t;

	// true for an aligned word at a mapped offset
	function automatic logic cpm_addr_hit(input logic [31:0] addr);
		return (addr == `CPM_OFS_STATUS) || (addr == `CPM_OFS_CONTROL) ||
			(addr == `CPM_OFS_DECODE);
	endfunction

endpackage

/* cpm_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none

// axi4-lite slave: one write and one read in flight, flat register port
module cpm_axil_slave
	import cpm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output var  logic        wr_en,
	output var  logic [31:0] wr_addr,
	output var  logic [31:0] wr_data,
	output var  logic [3:0]  wr_strb,
	output var  logic [31:0] rd_addr,
	input  wire logic [31:0] rd_data
);

	logic aw_full_reg;  // write address held
	logic w_full_reg;   // write data held
	logic ar_full_reg;  // read address held
	logic aw_full_next;
	logic w_full_next;
	logic ar_full_next;
	logic bvalid_next;
	logic rvalid_next;
	logic do_wr;        // both halves present, response slot free
	logic do_rd;

	// handshake bookkeeping; address and data may come in either order
	always_comb begin
		do_wr        = aw_full_reg & w_full_reg & ~s_axi_bvalid;
		do_rd        = ar_full_reg & ~s_axi_rvalid;
		aw_full_next = (aw_full_reg | (s_axi_awvalid & s_axi_awready)) & ~do_wr;
		w_full_next  = (w_full_reg | (s_axi_wvalid & s_axi_wready)) & ~do_wr;
		ar_full_next = (ar_full_reg | (s_axi_arvalid & s_axi_arready)) & ~do_rd;
		bvalid_next  = do_wr | (s_axi_bvalid & ~s_axi_bready);
		rvalid_next  = do_rd | (s_axi_rvalid & ~s_axi_rready);
	end

	// channel flags; readies are registered so no path runs to the pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			ar_full_reg   <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
		end else if (ce) begin
			aw_full_reg   <= aw_full_next;
			w_full_reg    <= w_full_next;
			ar_full_reg   <= ar_full_next;
			s_axi_bvalid  <= bvalid_next;
			s_axi_rvalid  <= rvalid_next;
			s_axi_awready <= ~aw_full_next & ~bvalid_next;
			s_axi_wready  <= ~w_full_next & ~bvalid_next;
			s_axi_arready <= ~ar_full_next & ~rvalid_next;
		end
	end

	// payload capture and the single-cycle write strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_addr     <= 32'h0000_0000;
			wr_data     <= 32'h0000_0000;
			wr_strb     <= 4'h0;
			wr_en       <= 1'b0;
			rd_addr     <= 32'h0000_0000;
			s_axi_bresp <= `CPM_RESP_OKAY;
			s_axi_rresp <= `CPM_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else if (ce) begin
			wr_en <= do_wr & cpm_addr_hit(wr_addr);
			if (s_axi_awvalid & s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (s_axi_arvalid & s_axi_arready) begin
				rd_addr <= s_axi_araddr;
			end
			// unmapped offsets answer slverr, reads return zero
			if (do_wr) begin
				s_axi_bresp <= cpm_addr_hit(wr_addr) ? `CPM_RESP_OKAY
					: `CPM_RESP_SLVERR;
			end
			if (do_rd) begin
				s_axi_rdata <= rd_data;
				s_axi_rresp <= cpm_addr_hit(rd_addr) ? `CPM_RESP_OKAY
					: `CPM_RESP_SLVERR;
			end
		end
	end

endmodule

`default_nettype wire

/* cpm_control_pin_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module cpm_control_pin_decode
	import cpm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        serial_reset_pin,
	input  wire logic        serial_port_clock_pin,
	input  wire logic        serial_port_data_pin,
	input  wire logic        serial_port_enable_pin,
	input  wire logic        global_powerdown_pin,
	input  wire logic        wire_count_clock_rate_select,
	input  wire logic        serialization_factor_select,
	input  wire logic        format_bit_order_select,
	output var  cpm_prog_t   prog_port,
	output var  logic        prog_regs_init,
	output var  cpm_mode_t   mode,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	cpm_pins_t   pins;            // current pin levels, one bundle
	cpm_pins_t   pins_reg;        // previous cycle, for edge detection
	logic [1:0]  control_reg;     // software control bits
	logic        wr_en;           // register write strobe
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [31:0] rd_addr;
	logic [31:0] rd_data;
	logic        soft_reset_hit;  // write of one to the soft reset bit
	logic        reset_rise;      // high-going edge on the serial reset pin
	logic [1:0]  par_code;        // static code on clock and data pins
	cpm_mode_t   mode_next;

	// pins are synchronous to aclk, so they are bundled without resampling
	assign pins = '{serial_reset: serial_reset_pin,
		clock: serial_port_clock_pin, data: serial_port_data_pin,
		enable: serial_port_enable_pin, powerdown: global_powerdown_pin,
		wire_rate: wire_count_clock_rate_select,
		factor: serialization_factor_select,
		format_order: format_bit_order_select};

	cpm_axil_slave u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data)
	);

	// soft reset is a write-one pulse; it never stays set in the register
	assign soft_reset_hit = wr_en && (wr_addr == `CPM_OFS_CONTROL) &&
		wr_strb[0] && wr_data[`CPM_CTL_SOFT_RESET];
	assign reset_rise = pins.serial_reset & ~pins_reg.serial_reset;
	assign par_code   = {pins.clock, pins.data};

	// control register: only the clock-rate bit is stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_reg <= `CPM_CTL_RESET_VAL;
		end else if (ce) begin
			if (wr_en && (wr_addr == `CPM_OFS_CONTROL) && wr_strb[0]) begin
				control_reg[`CPM_CTL_SDR_CLOCK] <=
					wr_data[`CPM_CTL_SDR_CLOCK];
			end
		end
	end

	// previous pin levels for the serial reset edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_reg <= '0;
		end else if (ce) begin
			pins_reg <= pins;
		end
	end

	// register init pulse from either the pin edge or software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_regs_init <= 1'b0;
		end else if (ce) begin
			prog_regs_init <= reset_rise | soft_reset_hit;
		end
	end

	// serial programming port: passed only while serial reset is low,
	// otherwise parked idle so the parallel levels cannot clock registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_port <= '{clock: 1'b0, data: 1'b0, enable: 1'b1};
		end else if (ce) begin
			if (!pins.serial_reset) begin
				prog_port.clock  <= pins.clock;
				prog_port.data   <= pins.data;
				prog_port.enable <= pins.enable;
			end else begin
				prog_port <= '{clock: 1'b0, data: 1'b0, enable: 1'b1};
			end
		end
	end

	// static mode decode; parallel modes hold while serial reset is high,
	// which the host keeps high for parallel use
	always_comb begin
		mode_next = '0;
		if (pins.serial_reset) begin
			mode_next.alignment_pattern_mode =
				(par_code == `CPM_PAR_ALIGN);
			mode_next.sync_mode = (par_code == `CPM_PAR_SYNC);
			mode_next.powerdown =
				(par_code == `CPM_PAR_POWERDOWN);
			mode_next.coarse_gain        = ~pins.enable;
			mode_next.external_reference = ~pins.enable;
		end
		// dedicated pin wins regardless of serial port role
		if (pins.powerdown) begin
			mode_next.powerdown = 1'b1;
		end
		// grounded pin: one wire; sdr only when software asks
		mode_next.two_wire  = pins.wire_rate;
		mode_next.sdr_clock = control_reg[`CPM_CTL_SDR_CLOCK];
		// in ddr the pin level is a don't care and 14x is used
		if (mode_next.sdr_clock) begin
			mode_next.factor_16x      = pins.factor;
			mode_next.capture_falling = ~pins.factor;
		end
		mode_next.offset_binary = pins.format_order;
		mode_next.lsb_first     = pins.format_order;
	end

	// mode outputs straight from flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode <= '0;
		end else if (ce) begin
			mode <= mode_next;
		end
	end

	// read mux: pin levels, control bits and decoded modes
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_addr)
			`CPM_OFS_STATUS:  rd_data[7:0]  = pins_reg;
			`CPM_OFS_CONTROL: rd_data[1:0]  = control_reg;
			`CPM_OFS_DECODE:  rd_data[10:0] = mode;
			default:          rd_data       = 32'h0000_0000;
		endcase
	end

endmodule

`default_nettype wire

/* cpm_pin_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// watches the pin decode from the top module's ports only
module cpm_pin_checker
	import cpm_pkg::*;
(
	input wire logic      aclk,
	input wire logic      aresetn,
	input wire logic      ce,
	input wire logic      serial_reset_pin,
	input wire logic      serial_port_clock_pin,
	input wire logic      serial_port_data_pin,
	input wire logic      serial_port_enable_pin,
	input wire logic      global_powerdown_pin,
	input wire logic      wire_count_clock_rate_select,
	input wire logic      serialization_factor_select,
	input wire logic      format_bit_order_select,
	input wire cpm_prog_t prog_port,
	input wire logic      prog_regs_init,
	input wire cpm_mode_t mode
);
	wire logic pclk = serial_port_clock_pin;   // shorter aliases
	wire logic pdat = serial_port_data_pin;
	wire logic pena = serial_port_enable_pin;
	wire logic fac  = serialization_factor_select;
	wire logic fmt  = format_bit_order_select;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// shared pins in parallel or in serial role
	// aresetn sits in every antecedent: disable iff sees the level after
	// the edge, so a release edge would start attempts on flops that were
	// still held in reset at that very edge
	sequence s_live; ce && aresetn; endsequence
	sequence s_par; ce && aresetn && serial_reset_pin; endsequence
	sequence s_ser; ce && aresetn && !serial_reset_pin; endsequence
	// clean low to high step, both samples taken with the clock enabled
	sequence s_rise; ce && aresetn && $past(ce) &&
		$rose(serial_reset_pin); endsequence

	a_prog_follow:
	assert property (s_ser |=> prog_port.clock == $past(pclk) &&
		prog_port.data == $past(pdat) && prog_port.enable == $past(pena))
		else $error("prog port lost the pins");
	a_prog_idle:
	assert property (s_par |=> prog_port == 3'h1)
		else $error("prog port not idle");
	a_par_code:
	assert property (s_par |=> mode.alignment_pattern_mode ==
		(!$past(pclk) && $past(pdat)) &&
		mode.sync_mode == ($past(pclk) && !$past(pdat)))
		else $error("parallel code decoded wrong");
	a_par_pdown:
	assert property (s_par ##0 (pclk && pdat) |=> mode.powerdown)
		else $error("parallel power down missed");
	a_pin_pdown:
	assert property (s_live ##0 global_powerdown_pin |=> mode.powerdown)
		else $error("power down pin ignored");
	a_gain_ref:
	assert property (s_par |=> mode.coarse_gain == !$past(pena) &&
		mode.external_reference == !$past(pena))
		else $error("gain or reference wrong");
	a_wire_count:
	assert property (s_live |=> mode.two_wire ==
		$past(wire_count_clock_rate_select))
		else $error("wire count wrong");
	a_factor_edge:
	assert property (s_live |=> mode.factor_16x ==
		(mode.sdr_clock && $past(fac)) &&
		mode.capture_falling == (mode.sdr_clock && !$past(fac)))
		else $error("factor or capture edge wrong");
	a_format_order:
	assert property (s_live |=> mode.offset_binary == $past(fmt) &&
		mode.lsb_first == $past(fmt))
		else $error("format or bit order wrong");
	a_init_pulse:
	assert property (s_rise |=> prog_regs_init)
		else $error("no init pulse");
endmodule

`default_nettype wire

/* cpm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// host side of the control pins: board straps or a serial programmer
module cpm_host_model
	import cpm_pkg::*;
(
	input  wire logic      aclk,
	output var  cpm_pins_t pins
);
	// released pins sit at pull levels: enable up, the rest down
	initial pins = 8'h10;

	// strapping keeps serial reset high until a frame lowers it
	task automatic strap(input cpm_pins_t v);
		@(posedge aclk);
		pins <= v | 8'h80;
	endtask

	// one programming word; hold sets cycles per clock half
	task automatic frame(input logic [7:0] w, input int hold);
		cpm_pins_t q;
		q = pins;
		q[7:4] = 4'h9; // registers are initialised by a pulse
		@(posedge aclk) pins <= q;
		q[7:4] = 4'h0; // enable low frames the word
		repeat (2) @(posedge aclk) pins <= q;
		for (int i = 7; i >= 0; i--) begin
			q[6:5] = {1'b0, w[i]}; // data changes while clock low
			repeat (hold) @(posedge aclk) pins <= q;
			q[6] = 1'b1;
			repeat (hold) @(posedge aclk) pins <= q;
		end
		q[6:4] = 3'h1; // back to pull levels, no stale data
		@(posedge aclk) pins <= q;
	endtask
endmodule

`default_nettype wire

/* control_pin_mode_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpm_regs.svh"

// count a comparison, report a miss at once
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin \
	miscompares++; $display("unexpected at %0t: %s", $time, msg); end end

module control_pin_mode_decode_test
	import cpm_pkg::*;
;
	logic        aclk = 0, aresetn = 0, ce = 1, chk_on = 0, wr_busy = 0;
	logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic        awr, wr, bv, arr, rv, prog_regs_init;
	logic        exp_init, prev_rst, exp_sdr;
	logic [31:0] aw = 0, wd = 0, ar = 0, rd;
	logic [1:0]  bres, rres;
	logic [10:0] exp_mode, care; // predicted mode and bits that are defined
	cpm_prog_t   prog_port, exp_prog;
	cpm_mode_t   mode;
	cpm_pins_t   pins, p;
	int          cmp_count = 0, miscompares = 0, cycles = 0, pulses = 0;
	int          seed = 32'h55ADAA8E;

	cpm_host_model host_u (.aclk, .pins);
	cpm_control_pin_decode dut_u (.aclk, .aresetn, .ce,
		.serial_reset_pin(pins.serial_reset),
		.serial_port_clock_pin(pins.clock),
		.serial_port_data_pin(pins.data),
		.serial_port_enable_pin(pins.enable),
		.global_powerdown_pin(pins.powerdown),
		.wire_count_clock_rate_select(pins.wire_rate),
		.serialization_factor_select(pins.factor),
		.format_bit_order_select(pins.format_order),
		.prog_port, .prog_regs_init, .mode,
		.s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rres),
		.s_axi_rvalid(rv), .s_axi_rready(rr));

	initial forever #2.5 aclk = ~aclk;

	// model: outputs at an edge answer the pins of the edge before
	always @(posedge aclk) begin
		if (wr_busy) care[4:2] = 3'h0; // rate bits move during a write
		if (chk_on) begin
			`CHK(prog_port, exp_prog, "prog port")
			`CHK(mode & care, exp_mode & care, "mode")
			if (!wr_busy) `CHK(prog_regs_init, exp_init, "init")
		end
		if (wr_busy && prog_regs_init)
			pulses++;
		p = pins;
		if (!aresetn) begin
			// programming port parks idle with enable high, all else clear
			{exp_prog, exp_init, prev_rst, exp_mode, exp_sdr} = 17'h04000;
			care = 11'h7FF;
		end else if (ce) begin
			exp_prog = p.serial_reset ? 3'h1 : p[6:4];
			exp_init = p.serial_reset && !prev_rst;
			prev_rst = p.serial_reset;
			// serial role clears the parallel fields; only the dedicated
			// power down pin still acts there
			exp_mode = {p.serial_reset && p[6:5] == 2'h1,
				p.serial_reset && p[6:5] == 2'h2,
				p.powerdown || (p.serial_reset && p[6:5] == 2'h3),
				p.serial_reset && !p.enable, p.serial_reset && !p.enable,
				p.wire_rate, exp_sdr, exp_sdr && p.factor,
				exp_sdr && !p.factor, p.format_order, p.format_order};
			care = 11'h7FF;
		end
	end

	// a hang counts as a miss
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			finish_test;
		end
	end

	task automatic finish_test;
		$display("compares %0d, misses %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// write one word; halves released as each is taken
	task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
		@(posedge aclk);
		wr_busy <= 1;
		{aw, wd} <= {a, d};
		{awv, wv, br} <= 3'h7;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
		end while (!bv);
		br <= 0;
		`CHK(bres, r, "write response")
		if (a == `CPM_OFS_CONTROL && r == `CPM_RESP_OKAY)
			exp_sdr = d[1];
		repeat (3) @(posedge aclk);
		wr_busy <= 0;
	endtask

	task automatic axr(input logic [31:0] a, x, input logic [1:0] r);
		@(posedge aclk);
		ar <= a;
		{arv, rr} <= 2'h3;
		do begin
			@(posedge aclk);
			if (arr) arv <= 0;
		end while (!rv);
		rr <= 0;
		`CHK(rd, x, "read data")
		`CHK(rres, r, "read response")
	endtask

	initial begin
		logic [31:0] r;
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		chk_on <= 1;
		axr(`CPM_OFS_CONTROL, 0, `CPM_RESP_OKAY);
		// every parallel code and gain level, both bit clock rates
		for (int s = 0; s < 2; s++) begin
			axw(`CPM_OFS_CONTROL, s * 2, `CPM_RESP_OKAY);
			for (int i = 0; i < 32; i++) begin
				r = $random(seed);
				host_u.strap({1'b1, i[1:0], i[2], r[3:2], i[3], r[0]});
				ce <= r[7:5] != 3'h0;
				repeat (3) @(posedge aclk);
			end
			ce <= 1;
			@(posedge aclk);
			axr(`CPM_OFS_STATUS, {24'h0, pins}, `CPM_RESP_OKAY);
			axr(`CPM_OFS_DECODE, {21'h0, exp_mode}, `CPM_RESP_OKAY);
		end
		done("parallel");
		pulses = 0;
		axw(`CPM_OFS_CONTROL, 3, `CPM_RESP_OKAY);
		`CHK(pulses, 1, "soft reset pulse")
		axr(`CPM_OFS_CONTROL, 2, `CPM_RESP_OKAY);
		done("soft reset");
		for (int k = 1; k < 4; k += 2)
			host_u.frame(8'($random(seed)), k);
		done("serial");
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		axr(`CPM_OFS_CONTROL, 0, `CPM_RESP_OKAY);
		pulses = 0;
		axw(32'h0000_000C, 3, `CPM_RESP_SLVERR);
		axr(32'h0000_000C, 0, `CPM_RESP_SLVERR);
		`CHK(pulses, 0, "refused write acted")
		done("refusal");
		finish_test;
	end
endmodule

bind cpm_control_pin_decode cpm_pin_checker chk_u (
	.aclk                         (aclk),
	.aresetn                      (aresetn),
	.ce                           (ce),
	.serial_reset_pin             (serial_reset_pin),
	.serial_port_clock_pin        (serial_port_clock_pin),
	.serial_port_data_pin         (serial_port_data_pin),
	.serial_port_enable_pin       (serial_port_enable_pin),
	.global_powerdown_pin         (global_powerdown_pin),
	.wire_count_clock_rate_select (wire_count_clock_rate_select),
	.serialization_factor_select  (serialization_factor_select),
	.format_bit_order_select      (format_bit_order_select),
	.prog_port                    (prog_port),
	.prog_regs_init               (prog_regs_init),
	.mode                         (mode)
);

`default_nettype wire
